// [design/rwg_status_gate.sv]
`timescale 1ns/1ps
// Function
// RULE_01: Write gate cleared at power-up
// RULE_02: Gate clear discards writes, still acked
// RULE_03: Status write 02h sets write gate
// RULE_04: Gate holds until 00h write or reset
// RULE_05: Gate writes need no programming wait
// RULE_06: Flag set after total loss, unwritable
// RULE_07: Flag needs both supplies lost, any order
// RULE_08: Total loss reloads all register defaults
// RULE_09: Counters held until clock section written
// RULE_10: First clock-section byte clears flag
// RULE_11: Control gate also needed for writes
// RULE_12: Status at 3Fh, bits flag/gate/control
module rwg_status_gate (
    // Core clock and power-on reset
    input wire logic clock,
    input wire logic arst_n,
    // Supply monitor: high when both supplies had dropped
    input wire logic totalLossSense,
    // Link clock and decoded byte writes
    input wire logic linkClock,
    input wire logic linkWrValid,
    input wire logic [5:0] linkAddr,
    input wire logic [7:0] linkData,
    // Link answers
    output logic linkAck,
    output logic [7:0] linkRdData,
    // Accepted clock/control space writes
    output logic ccrWrStrobe,
    output logic [5:0] ccrWrAddr,
    output logic [7:0] ccrWrData,
    // Status and timekeeping control
    output logic regWriteGate,
    output logic ctrlSpaceWriteGate,
    output logic totalPowerLossFlag,
    output logic countHold,
    output logic loadDefaults
);

    rwg_xfer_if xfer (); // Link to core crossing

    // Link-domain half
    rwg_link_port u_link (
        .linkClock(linkClock),
        .arst_n(arst_n),
        .linkWrValid(linkWrValid),
        .linkAddr(linkAddr),
        .linkData(linkData),
        .linkAck(linkAck),
        .linkRdData(linkRdData),
        .xfer(xfer)
    );

    rwg_pkg::rwg_core_t st; // Registered state
    rwg_pkg::rwg_core_t next_st; // Next state
    logic wrEvent; // One core cycle per handed-over byte
    logic isStatus; // Byte targets the status byte
    logic isRtc; // Byte targets the clock section

    // Toggle edge seen after the two-stage sync
    assign wrEvent = st.togSync ^ st.togSeen;
    assign isStatus = (xfer.wrAddr == rwg_pkg::STATUS_ADDR);
    assign isRtc = (xfer.wrAddr >= rwg_pkg::RTC_LO_ADDR) && (xfer.wrAddr <= rwg_pkg::RTC_HI_ADDR);

    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.loadDefaults = 1'b0;
        next_st.ccrStrobe = 1'b0;
        // Synchronisers; first stages feed only second stages
        next_st.senseMeta = totalLossSense;
        next_st.senseSync = st.senseMeta;
        next_st.togMeta = xfer.wrToggle;
        next_st.togSync = st.togMeta;
        next_st.togSeen = st.togSync;
        if (!st.started) begin
            // Wait until the sense level has crossed over
            next_st.startCnt = st.startCnt + 2'h1;
            if (st.startCnt == rwg_pkg::STARTUP_CYCLES - 2'h1) begin
                next_st.started = 1'b1;
                // Sense already combines both supplies, any order
                next_st.flag = st.senseSync; // RULE_06 RULE_07
                next_st.countHold = st.senseSync; // RULE_09
                next_st.loadDefaults = st.senseSync; // RULE_08
            end
        end else if (wrEvent) begin
            if (isStatus) begin
                // Only exact patterns act; flag bit is read-only
                case (xfer.wrData)
                    rwg_pkg::CMD_CLEAR: begin
                        next_st.regGate = 1'b0; // RULE_04
                        next_st.ctrlGate = 1'b0;
                    end
                    rwg_pkg::CMD_SET_REG: begin
                        next_st.regGate = 1'b1; // RULE_03
                        next_st.ctrlGate = 1'b0;
                    end
                    rwg_pkg::CMD_SET_BOTH: begin
                        // Control gate only as the second step
                        next_st.ctrlGate = st.regGate; // RULE_11
                    end
                    default: begin
                        // Other patterns ignored
                        next_st.regGate = st.regGate;
                    end
                endcase
            end else if (st.regGate && st.ctrlGate) begin
                // Accepted byte goes out at once, no programming busy
                next_st.ccrStrobe = 1'b1; // RULE_05 RULE_11
                next_st.ccrAddr = xfer.wrAddr;
                next_st.ccrData = xfer.wrData;
                if (isRtc) begin
                    // One byte is enough to release the counters
                    next_st.flag = 1'b0; // RULE_10
                    next_st.countHold = 1'b0; // RULE_09
                end
            end
            // Otherwise the byte is silently dropped
        end
    end

    // Core registers; reset is power-up, so nothing is retained
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            st.regGate <= rwg_pkg::RST_REG_GATE; // RULE_01
            st.ctrlGate <= rwg_pkg::RST_CTRL_GATE;
            st.flag <= rwg_pkg::RST_FLAG; // RULE_08 RULE_12
            st.countHold <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign ccrWrStrobe = st.ccrStrobe;
    assign ccrWrAddr = st.ccrAddr;
    assign ccrWrData = st.ccrData;
    assign regWriteGate = st.regGate;
    assign ctrlSpaceWriteGate = st.ctrlGate;
    assign totalPowerLossFlag = st.flag;
    assign countHold = st.countHold;
    assign loadDefaults = st.loadDefaults;
    // Status bits back to the link domain
    assign xfer.status[rwg_pkg::FLAG_BIT] = st.flag; // RULE_12
    assign xfer.status[rwg_pkg::REG_GATE_BIT] = st.regGate;
    assign xfer.status[rwg_pkg::CTRL_GATE_BIT] = st.ctrlGate;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // Gate is clear when startup ends
    property p_gate_clear_at_start;
        $rose(st.started) |-> !regWriteGate && !ctrlSpaceWriteGate;
    endproperty
    a_gate_clear_at_start: assert property (p_gate_clear_at_start) // RULE_01
        else $error("write gate set after power-up");

    // Closed gate drops non-status bytes
    property p_closed_drops;
        st.started && wrEvent && !isStatus && !(regWriteGate && ctrlSpaceWriteGate) |=> !ccrWrStrobe;
    endproperty
    a_closed_drops: assert property (p_closed_drops) // RULE_02
        else $error("write passed closed gate");

    // Set pattern opens the gate
    property p_set_gate;
        st.started && wrEvent && isStatus && xfer.wrData == 8'h02 |=> regWriteGate;
    endproperty
    a_set_gate: assert property (p_set_gate) // RULE_03
        else $error("gate not set by 02h");

    // Gate falls only on the clear pattern
    property p_gate_holds;
        $fell(regWriteGate) |-> $past(wrEvent && isStatus && xfer.wrData == 8'h00);
    endproperty
    a_gate_holds: assert property (p_gate_holds) // RULE_04
        else $error("gate dropped without clear");

    // Open gates pass a byte on the next edge
    property p_open_passes;
        st.started && wrEvent && !isStatus && regWriteGate && ctrlSpaceWriteGate
            |=> ccrWrStrobe && ccrWrAddr == $past(xfer.wrAddr);
    endproperty
    a_open_passes: assert property (p_open_passes) // RULE_05
        else $error("accepted byte not issued");

    // Status writes never touch the flag
    property p_flag_unwritable;
        st.started && wrEvent && isStatus |=> $stable(totalPowerLossFlag);
    endproperty
    a_flag_unwritable: assert property (p_flag_unwritable) // RULE_06
        else $error("flag changed by status write");

    // Startup with loss sensed sets flag and pulses defaults
    property p_loss_capture;
        $rose(st.started) && $past(st.senseSync) |-> totalPowerLossFlag && countHold && loadDefaults ##1 !loadDefaults;
    endproperty
    a_loss_capture: assert property (p_loss_capture) // RULE_08
        else $error("total loss not captured");

    // Counters held as long as the flag stands
    property p_hold_with_flag;
        st.started && totalPowerLossFlag |-> countHold;
    endproperty
    a_hold_with_flag: assert property (p_hold_with_flag) // RULE_09
        else $error("counters run while flag set");

    // Flag falls only by an accepted clock-section byte
    property p_flag_clear_cause;
        // Startup with no loss also lowers the reset value; only drops while running count
        $fell(totalPowerLossFlag) && $past(st.started)
            |-> ccrWrStrobe && ccrWrAddr >= rwg_pkg::RTC_LO_ADDR && ccrWrAddr <= rwg_pkg::RTC_HI_ADDR;
    endproperty
    a_flag_clear_cause: assert property (p_flag_clear_cause) // RULE_10
        else $error("flag cleared without clock write");

    // Control gate rises only behind the write gate
    property p_ctrl_after_reg;
        $rose(ctrlSpaceWriteGate) |-> $past(regWriteGate) && regWriteGate;
    endproperty
    a_ctrl_after_reg: assert property (p_ctrl_after_reg) // RULE_11
        else $error("control gate set without write gate");

endmodule // rwg_status_gate

// [design/rwg_pkg.sv]
// Shared constants and types for the status write-gate block
package rwg_pkg;

    // Clock/control space address width and status byte location
    localparam int ADDR_W = 6;
    localparam logic [5:0] STATUS_ADDR = 6'h3f;
    // Clock (timekeeping) section bounds
    localparam logic [5:0] RTC_LO_ADDR = 6'h30;
    localparam logic [5:0] RTC_HI_ADDR = 6'h37;

    // Status byte field positions
    localparam int FLAG_BIT = 0;
    localparam int REG_GATE_BIT = 1;
    localparam int CTRL_GATE_BIT = 2;
    localparam int STATUS_W = 3;

    // Status byte command values (only exact patterns act)
    localparam logic [7:0] CMD_CLEAR = 8'h00;
    localparam logic [7:0] CMD_SET_REG = 8'h02;
    localparam logic [7:0] CMD_SET_BOTH = 8'h06;

    // Values after reset
    localparam logic RST_REG_GATE = 1'b0;
    localparam logic RST_CTRL_GATE = 1'b0;
    localparam logic RST_FLAG = 1'b1;

    // Cycles after reset release before the loss sense is trusted
    localparam logic [1:0] STARTUP_CYCLES = 2'h3;

    // Core-domain state
    typedef struct packed {
        logic started;
        logic [1:0] startCnt;
        logic senseMeta;
        logic senseSync;
        logic togMeta;
        logic togSync;
        logic togSeen;
        logic regGate;
        logic ctrlGate;
        logic flag;
        logic countHold;
        logic loadDefaults;
        logic ccrStrobe;
        logic [5:0] ccrAddr;
        logic [7:0] ccrData;
    } rwg_core_t;

    // Link-domain state
    typedef struct packed {
        logic ack;
        logic tog;
        logic [5:0] addr;
        logic [7:0] data;
        logic [2:0] stMeta;
        logic [2:0] stSync;
        logic [7:0] rdData;
    } rwg_link_t;

endpackage

// [design/rwg_xfer_if.sv]
`timescale 1ns/1ps
// Carries byte writes from the link domain and status back to it
interface rwg_xfer_if;
    logic wrToggle; // Flips once per written byte
    logic [5:0] wrAddr; // Held stable until the next byte
    logic [7:0] wrData; // Held stable until the next byte
    logic [2:0] status; // Core-domain gate and flag levels

    modport link (
        output wrToggle,
        output wrAddr,
        output wrData,
        input status
    );

    modport core (
        input wrToggle,
        input wrAddr,
        input wrData,
        output status
    );
endinterface

// [design/rwg_link_port.sv]
`timescale 1ns/1ps
// Link-side byte port: acknowledges every byte, hands it to the core
module rwg_link_port (
    // Link clock and reset
    input wire logic linkClock,
    input wire logic arst_n,
    // Decoded byte write from the serial front end
    input wire logic linkWrValid,
    input wire logic [5:0] linkAddr,
    input wire logic [7:0] linkData,
    // Answers toward the serial front end
    output logic linkAck,
    output logic [7:0] linkRdData,
    // Crossing toward the core
    rwg_xfer_if.link xfer
);

    rwg_pkg::rwg_link_t st; // Registered state
    rwg_pkg::rwg_link_t next_st; // Next state

    // Capture byte, flip toggle, resync status
    always_comb begin
        next_st = st;
        // Every byte is acked, even ones the core will discard
        next_st.ack = linkWrValid; // RULE_02
        if (linkWrValid) begin
            next_st.addr = linkAddr;
            next_st.data = linkData;
            next_st.tog = ~st.tog;
        end
        // Two-stage sync of core levels
        next_st.stMeta = xfer.status;
        next_st.stSync = st.stMeta;
        // Status byte image, undefined bits read zero
        next_st.rdData = {5'h00, st.stSync}; // RULE_12
    end

    // Link-domain registers; clock may stop between frames
    always_ff @(posedge linkClock or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign linkAck = st.ack;
    assign linkRdData = st.rdData;
    assign xfer.wrToggle = st.tog;
    assign xfer.wrAddr = st.addr;
    assign xfer.wrData = st.data;

    // No programming wait: ack follows each byte at once
    property p_ack_every_byte;
        @(posedge linkClock) disable iff (!arst_n)
        linkWrValid |=> linkAck;
    endproperty
    a_ack_every_byte: assert property (p_ack_every_byte) // RULE_02
        else $error("byte not acknowledged");

    // Back-to-back bytes each hand over a toggle
    property p_toggle_per_byte;
        @(posedge linkClock) disable iff (!arst_n)
        linkWrValid |=> (xfer.wrToggle != $past(xfer.wrToggle)) && (xfer.wrData == $past(linkData));
    endproperty
    a_toggle_per_byte: assert property (p_toggle_per_byte) // RULE_05
        else $error("byte not handed to core");

endmodule // rwg_link_port

// [sim/rwg_host_model.sv]
`timescale 1ns/1ps
// Serial host stand-in: decoded byte writes on a link clock that runs only in frames
module rwg_host_model (
    // Link clock and byte request
    output logic linkClock,
    output logic linkWrValid,
    output logic [5:0] linkAddr,
    output logic [7:0] linkData,
    // Answer from the device
    input wire logic linkAck
);
    logic [13:0] byteQ [$]; // Pending {address, data} bytes
    logic busy; // High while a frame is queued or running
    logic kick; // Starts an empty frame, e.g. to clock reset in
    int ackCount; // Acknowledge pulses seen
    int tail; // Idle link cycles at the end of a frame

    // Queue one byte; the frame starts on its own
    task automatic put(input logic [5:0] a, input logic [7:0] d);
        byteQ.push_back({a, d});
        busy = 1'b1;
    endtask

    // Run the link clock without bytes
    task automatic run();
        busy = 1'b1;
        kick = 1'b1;
    endtask

    // Frame engine: clock stands still between frames
    initial begin
        linkClock = 1'b0;
        linkWrValid = 1'b0;
        linkAddr = 6'h00;
        linkData = 8'h00;
        busy = 1'b0;
        kick = 1'b0;
        ackCount = 0;
        forever begin
            wait (byteQ.size() != 0 || kick);
            kick = 1'b0;
            tail = 0;
            #33; // Phase unrelated to the core clock
            while (tail < 5) begin
                #80;
                // Sample before the edge, so the previous answer has settled
                if (linkAck === 1'b1) begin
                    ackCount++;
                end
                linkClock = 1'b1;
                if (byteQ.size() != 0) begin
                    {linkAddr, linkData} <= byteQ.pop_front();
                    linkWrValid <= 1'b1;
                    tail = 0;
                end else begin
                    // Released lines show a changing pattern, not the old byte
                    linkWrValid <= 1'b0;
                    linkAddr <= ~linkAddr;
                    linkData <= ~linkData;
                    tail++;
                end
                #80 linkClock = 1'b0;
            end
            busy = 1'b0;
        end
    end
endmodule // rwg_host_model

// [sim/testbench.sv]
`timescale 1ns/1ps
// Self-checking bench for the status write-gate block
module testbench;
    // One table row: a byte and what it should leave behind
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
        logic [2:0] status; // {ctrl gate, write gate, flag}
        logic strobe;
        logic [13:0] last; // Last accepted {address, data}
    } rwg_row_t;

    logic clock; // Core clock
    logic arst_n; // Power-on reset
    logic totalLossSense; // Both supplies had dropped
    logic linkClock, linkWrValid, linkAck, ccrWrStrobe;
    logic [5:0] linkAddr, ccrWrAddr;
    logic [7:0] linkData, linkRdData, ccrWrData;
    logic regWriteGate, ctrlSpaceWriteGate, totalPowerLossFlag, countHold, loadDefaults;
    int badCount, testsRun, strobeCount, loadCount, s0, a0;
    rwg_row_t rows [14] = '{
        '{6'h30, 8'h55, 3'h1, 1'b0, 14'h0000}, '{6'h3f, 8'h03, 3'h1, 1'b0, 14'h0000},
        '{6'h3f, 8'h02, 3'h3, 1'b0, 14'h0000}, '{6'h30, 8'h11, 3'h3, 1'b0, 14'h0000},
        '{6'h3f, 8'h06, 3'h7, 1'b0, 14'h0000}, '{6'h20, 8'haa, 3'h7, 1'b1, {6'h20, 8'haa}},
        '{6'h31, 8'h12, 3'h6, 1'b1, {6'h31, 8'h12}}, '{6'h3f, 8'h01, 3'h6, 1'b0, {6'h31, 8'h12}},
        '{6'h3f, 8'h00, 3'h0, 1'b0, {6'h31, 8'h12}}, '{6'h31, 8'h34, 3'h0, 1'b0, {6'h31, 8'h12}},
        // Control gate refused without write gate; 02h drops the control gate again
        '{6'h3f, 8'h06, 3'h0, 1'b0, {6'h31, 8'h12}}, '{6'h3f, 8'h02, 3'h2, 1'b0, {6'h31, 8'h12}},
        '{6'h3f, 8'h06, 3'h6, 1'b0, {6'h31, 8'h12}}, '{6'h3f, 8'h02, 3'h2, 1'b0, {6'h31, 8'h12}}};

    rwg_status_gate i_dut (.clock(clock), .arst_n(arst_n), .totalLossSense(totalLossSense),
        .linkClock(linkClock), .linkWrValid(linkWrValid), .linkAddr(linkAddr), .linkData(linkData),
        .linkAck(linkAck), .linkRdData(linkRdData), .ccrWrStrobe(ccrWrStrobe), .ccrWrAddr(ccrWrAddr),
        .ccrWrData(ccrWrData), .regWriteGate(regWriteGate), .ctrlSpaceWriteGate(ctrlSpaceWriteGate),
        .totalPowerLossFlag(totalPowerLossFlag), .countHold(countHold), .loadDefaults(loadDefaults));
    rwg_host_model i_host (.linkClock(linkClock), .linkWrValid(linkWrValid), .linkAddr(linkAddr),
        .linkData(linkData), .linkAck(linkAck));

    // Core clock, 10 ns
    always #5 clock = ~clock;

    // Count one-cycle pulses of the core outputs
    always @(posedge clock) begin
        strobeCount += (ccrWrStrobe === 1'b1);
        loadCount += (loadDefaults === 1'b1);
    end

    // Compare and report
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        testsRun++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Wait for the host frame to finish, bounded
    task automatic settle();
        for (int i = 0; i < 400 && i_host.busy; i++) @(posedge clock);
        // A frame still running here is a hang, counted as a mismatch
        if (i_host.busy) begin
            badCount++;
        end
        repeat (4) @(posedge clock);
    endtask

    // Power cycle with a given supply-loss level; link clock runs meanwhile
    task automatic power_up(input logic lost);
        arst_n <= 1'b0;
        totalLossSense <= lost;
        i_host.run();
        repeat (10) @(posedge clock);
        check(16'({ctrlSpaceWriteGate, regWriteGate, totalPowerLossFlag, countHold}), 16'h3);
        settle();
        arst_n <= 1'b1;
        repeat (8) @(posedge clock);
    endtask

    // Single verdict and end of run
    task automatic end_sim();
        if (badCount == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog against a hung frame
    initial begin
        #200000;
        badCount++;
        end_sim();
    end

    // Main sequence
    initial begin
        clock = 1'b0;
        arst_n = 1'b0;
        totalLossSense = 1'b1;
        {badCount, testsRun, strobeCount, loadCount} = '0;
        power_up(1'b1);
        check({loadDefaults, 15'(loadCount)}, 16'h1);
        check(16'({totalPowerLossFlag, countHold}), 16'h3);
        // Table: gate sequence, refused writes, flag clearing
        foreach (rows[i]) begin
            s0 = strobeCount;
            a0 = i_host.ackCount;
            @(posedge clock);
            i_host.put(rows[i].addr, rows[i].data);
            settle();
            check(16'(i_host.ackCount - a0), 16'h1);
            check(16'(strobeCount - s0), {15'h0, rows[i].strobe});
            check({ctrlSpaceWriteGate, regWriteGate, totalPowerLossFlag}, rows[i].status);
            check(16'(countHold), 16'(rows[i].status[0]));
            check(16'({ccrWrAddr, ccrWrData}), 16'(rows[i].last));
            check(16'(linkRdData), {13'h0000, rows[i].status});
        end
        // Back-to-back gate writes need no programming wait
        a0 = i_host.ackCount;
        i_host.put(6'h3f, 8'h02);
        i_host.put(6'h3f, 8'h06);
        settle();
        check(16'(i_host.ackCount - a0), 16'h2);
        check(16'({ctrlSpaceWriteGate, regWriteGate}), 16'h3);
        // Mid-run power cycle with one supply kept: gates drop, flag clear again once startup ends
        power_up(1'b0);
        check(16'({ctrlSpaceWriteGate, regWriteGate, totalPowerLossFlag, countHold}), 16'h0);
        check(16'(loadCount), 16'h1);
        end_sim();
    end
endmodule // testbench
